// File: drc_pkg.sv
// Shared constants, register map and state codes of the debug link rate loader.
package drc_pkg;

    // Clock and link timing.
    localparam int SYS_CLK_KHZ = 200000;
    localparam int SYS_CLK_NS  = 5;
    localparam int LINK_RATIO  = 4;
    localparam int DIV_W       = 12;
    localparam int DEF_HI_KHZ  = 8000;
    localparam int DEF_LO_KHZ  = 131;
    localparam logic [DIV_W-1:0] HALF_DEF_HI =
        DIV_W'((SYS_CLK_KHZ * LINK_RATIO + 2 * DEF_HI_KHZ - 1) / (2 * DEF_HI_KHZ));
    localparam logic [DIV_W-1:0] HALF_DEF_LO =
        DIV_W'((SYS_CLK_KHZ * LINK_RATIO + 2 * DEF_LO_KHZ - 1) / (2 * DEF_LO_KHZ));
    localparam int TGT_RST_NS  = 1000;
    localparam int TGT_RST_CYC = (TGT_RST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int RST_CNT_W   = 8;

    // Shadow set geometry.
    localparam int DATA_W    = 16;
    localparam int SHADOW_N  = 8;
    localparam int SHADOW_AW = 3;
    localparam logic [SHADOW_AW-1:0] SYNTH_IDX = 3'h0;
    localparam logic [SHADOW_AW-1:0] LAST_IDX  = 3'h7;

    // Register map on the plain port.
    localparam int ADDR_W = 8;
    localparam int BUS_W  = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h04;
    localparam logic [ADDR_W-1:0] DIV_OFS    = 8'h08;
    localparam logic [2:0]        SHADOW_SEL = 3'h1;
    localparam int CTRL_APPLY_BIT   = 0;
    localparam int CTRL_GENERIC_BIT = 1;
    localparam int CTRL_CODE_LSB    = 4;
    localparam int CODE_W           = 3;
    localparam logic [CODE_W-1:0] CODE_RST = 3'h1;
    localparam logic              GENERIC_RST = 1'b0;

    // Clock setting table: code to least target clock in kHz.
    function automatic logic [DIV_W-1:0] half_for_code(input logic [CODE_W-1:0] code);
        int khz;
        case (code)
            3'h0:    khz = DEF_LO_KHZ;
            3'h1:    khz = DEF_HI_KHZ;
            3'h2:    khz = 12000;
            3'h3:    khz = 16000;
            3'h4:    khz = 20000;
            3'h5:    khz = 25000;
            3'h6:    khz = 33000;
            default: khz = 40000;
        endcase
        return DIV_W'((SYS_CLK_KHZ * LINK_RATIO + 2 * khz - 1) / (2 * khz));
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RESET   = 3'b001,
        ST_DEFRATE = 3'b010,
        ST_LOAD    = 3'b011,
        ST_MAXRATE = 3'b100,
        ST_DONE    = 3'b101
    } drc_state_e;

endpackage

// File: drc_rate_div.sv
// Divider that makes the serial debug clock from a half-period count.
`timescale 1ns/1ps
module drc_rate_div
    import drc_pkg::*;
(
    // Clock and reset.
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    // Half period in system clocks.
    input  wire logic [DIV_W-1:0] half_i,
    // Divided clock.
    output logic                  link_clk_o
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic [DIV_W-1:0] half_r;
    logic             clk_r;
    logic             clk_nxt;

    // A new rate restarts the phase, so no half period is ever shorter than either rate allows.
    always_comb begin
        cnt_nxt = cnt_r + 1'b1;
        clk_nxt = clk_r;
        if (half_i != half_r) begin
            cnt_nxt = '0;
        end else if (cnt_r >= half_r - 1'b1) begin
            cnt_nxt = '0;
            clk_nxt = ~clk_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_r  <= '0;
            clk_r  <= 1'b0;
            half_r <= HALF_DEF_HI;
        end else begin
            cnt_r  <= cnt_nxt;
            clk_r  <= clk_nxt;
            half_r <= half_i;
        end
    end

    assign link_clk_o = clk_r;
endmodule

// File: drc_shadow_bank.sv
// Flip-flop store of the shadow register set with one write and two read ports.
`timescale 1ns/1ps
module drc_shadow_bank
    import drc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    // Write port.
    input  wire logic                 wr_i,
    input  wire logic [SHADOW_AW-1:0] wr_idx_i,
    input  wire logic [DATA_W-1:0]    wr_data_i,
    // Read ports.
    input  wire logic [SHADOW_AW-1:0] rd_a_idx_i,
    output logic [DATA_W-1:0]         rd_a_data_o,
    input  wire logic [SHADOW_AW-1:0] rd_b_idx_i,
    output logic [DATA_W-1:0]         rd_b_data_o
);
    logic [DATA_W-1:0] mem_r   [SHADOW_N];
    logic [DATA_W-1:0] mem_nxt [SHADOW_N];

    always_comb begin
        for (int i = 0; i < SHADOW_N; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_i) begin
            mem_nxt[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < SHADOW_N; i++) begin
            if (sys_rst_i) begin
                mem_r[i] <= '0;
            end else begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    assign rd_a_data_o = mem_r[rd_a_idx_i];
    assign rd_b_data_o = mem_r[rd_b_idx_i];
endmodule

// File: drc_loader_top.sv
// Configuration sequencer that resets the target, loads the shadow set and sets the debug link rate.
//
// Contract
// - Applying a configuration starts the link at the switch-selected default rate.
// - The synthesizer shadow is written to the target while still at default rate.
// - After the synthesizer load, the link rises to the configured maximum rate.
// - A target reset during user code leaves the link rate unchanged.
// - A target reset in the debug monitor reruns default rate, load, rate raise.
// - Software-entered initial values are kept as one shadow entry per target register.
// - Applying a configuration writes every shadow entry to its target register, except the synthesizer entry with the generic type.
// - The target is reset before the shadow set is written.
// - With the generic processor type the synthesizer load step is skipped.
// - A link rate above the real target clock makes debug operations fail.
// - Reapplying with a clock setting the target meets regains control.
// - Switch closed selects the higher default rate, open the lower one.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module drc_loader_top
    import drc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    // Register port.
    input  wire logic [ADDR_W-1:0]    reg_addr_i,
    input  wire logic [BUS_W-1:0]     reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic [BUS_W-1:0]          reg_rdata_o,
    // Default rate switch, high when closed.
    input  wire logic                 default_rate_switch_i,
    // Target state from the debug port engine.
    input  wire logic                 tgt_reset_seen_i,
    input  wire logic                 tgt_in_monitor_i,
    // Target register write request to the debug port engine.
    output logic                      tgt_wr_o,
    output logic [SHADOW_AW-1:0]      tgt_wr_idx_o,
    output logic [DATA_W-1:0]         tgt_wr_data_o,
    input  wire logic                 tgt_wr_done_i,
    // Target reset and serial debug clock.
    output logic                      tgt_reset_o,
    output logic                      dbg_clk_o
);
    drc_state_e            state_r;
    drc_state_e            state_nxt;
    logic [RST_CNT_W-1:0]  rst_cnt_r;
    logic [RST_CNT_W-1:0]  rst_cnt_nxt;
    logic [SHADOW_AW-1:0]  idx_r;
    logic [SHADOW_AW-1:0]  idx_nxt;
    logic [DIV_W-1:0]      half_r;
    logic [DIV_W-1:0]      half_nxt;
    logic                  def_sel_r;
    logic                  def_sel_nxt;
    logic                  run_generic_r;
    logic                  run_generic_nxt;
    logic [CODE_W-1:0]     run_code_r;
    logic [CODE_W-1:0]     run_code_nxt;
    logic                  ctrl_generic_r;
    logic                  ctrl_generic_nxt;
    logic [CODE_W-1:0]     ctrl_code_r;
    logic [CODE_W-1:0]     ctrl_code_nxt;
    logic                  tgt_wr_r;
    logic                  tgt_wr_nxt;
    logic [SHADOW_AW-1:0]  tgt_idx_r;
    logic [SHADOW_AW-1:0]  tgt_idx_nxt;
    logic [DATA_W-1:0]     tgt_data_r;
    logic [DATA_W-1:0]     tgt_data_nxt;
    logic                  tgt_rst_r;
    logic                  tgt_rst_nxt;
    logic [BUS_W-1:0]      rdata_r;
    logic [BUS_W-1:0]      rdata_nxt;
    logic                  apply;
    logic                  mon_reset;
    logic                  shadow_hit;
    logic                  shadow_wr;
    logic [SHADOW_AW-1:0]  shadow_idx;
    logic [DATA_W-1:0]     load_data;
    logic [DATA_W-1:0]     reg_shadow_data;
    logic [DIV_W-1:0]      def_half;
    logic [SHADOW_AW-1:0]  first_idx;

    // Register decode.
    assign shadow_hit = (reg_addr_i[7:5] == SHADOW_SEL) && (reg_addr_i[1:0] == 2'b00);
    assign shadow_idx = reg_addr_i[4:2];
    assign shadow_wr  = reg_wr_i && shadow_hit;
    assign apply      = reg_wr_i && (reg_addr_i == CTRL_OFS) && reg_wdata_i[CTRL_APPLY_BIT];
    // A reset seen while the loader itself holds the target down is its own and is not counted.
    assign mon_reset  = tgt_reset_seen_i && tgt_in_monitor_i && (state_r != ST_RESET);
    assign def_half   = def_sel_r ? HALF_DEF_HI : HALF_DEF_LO;
    assign first_idx  = run_generic_nxt ? (SYNTH_IDX + 1'b1) : SYNTH_IDX;

    drc_shadow_bank u_bank (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .wr_i        (shadow_wr),
        .wr_idx_i    (shadow_idx),
        .wr_data_i   (reg_wdata_i[DATA_W-1:0]),
        .rd_a_idx_i  (idx_nxt),
        .rd_a_data_o (load_data),
        .rd_b_idx_i  (shadow_idx),
        .rd_b_data_o (reg_shadow_data)
    );

    drc_rate_div u_div (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .half_i     (half_r),
        .link_clk_o (dbg_clk_o)
    );

    // Control register.
    always_comb begin
        ctrl_generic_nxt = ctrl_generic_r;
        ctrl_code_nxt    = ctrl_code_r;
        if (reg_wr_i && (reg_addr_i == CTRL_OFS)) begin
            ctrl_generic_nxt = reg_wdata_i[CTRL_GENERIC_BIT];
            ctrl_code_nxt    = reg_wdata_i[CTRL_CODE_LSB +: CODE_W];
        end
    end

    // Sequencer. A new apply wins over everything, so a bad setting can always be replaced.
    always_comb begin
        state_nxt       = state_r;
        rst_cnt_nxt     = rst_cnt_r;
        idx_nxt         = idx_r;
        half_nxt        = half_r;
        def_sel_nxt     = def_sel_r;
        run_generic_nxt = run_generic_r;
        run_code_nxt    = run_code_r;
        if (apply) begin
            state_nxt       = ST_RESET;
            rst_cnt_nxt     = '0;
            def_sel_nxt     = default_rate_switch_i;
            run_generic_nxt = reg_wdata_i[CTRL_GENERIC_BIT];
            run_code_nxt    = reg_wdata_i[CTRL_CODE_LSB +: CODE_W];
        end else if (mon_reset) begin
            // The target dropped its synthesizer setting, so the whole load runs again.
            state_nxt = ST_DEFRATE;
        end else begin
            // A reset during user code falls through here and leaves the rate alone.
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_RESET: begin
                    rst_cnt_nxt = rst_cnt_r + 1'b1;
                    if (rst_cnt_r == RST_CNT_W'(TGT_RST_CYC - 1)) begin
                        state_nxt = ST_DEFRATE;
                    end
                end
                ST_DEFRATE: begin
                    half_nxt  = def_half;
                    idx_nxt   = first_idx;
                    state_nxt = ST_LOAD;
                end
                ST_LOAD: begin
                    // Each entry is written once per pass, as some targets take only one write.
                    if (tgt_wr_done_i && tgt_wr_r) begin
                        if (idx_r == LAST_IDX) begin
                            state_nxt = ST_MAXRATE;
                        end else begin
                            idx_nxt = idx_r + 1'b1;
                        end
                    end
                end
                ST_MAXRATE: begin
                    // The rate is trusted as set; too high a setting breaks debug access until reapplied.
                    half_nxt  = half_for_code(run_code_r);
                    state_nxt = ST_DONE;
                end
                ST_DONE: begin
                    state_nxt = ST_DONE;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Target side outputs follow the next state so they leave flip-flops in step with it.
    always_comb begin
        tgt_rst_nxt  = (state_nxt == ST_RESET);
        tgt_wr_nxt   = (state_nxt == ST_LOAD) && !(tgt_wr_done_i && tgt_wr_r);
        tgt_idx_nxt  = idx_nxt;
        tgt_data_nxt = load_data;
    end

    // Read data, one cycle after the read strobe and only then.
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_i) begin
            if (reg_addr_i == CTRL_OFS) begin
                rdata_nxt[CTRL_GENERIC_BIT]               = ctrl_generic_r;
                rdata_nxt[CTRL_CODE_LSB +: CODE_W]        = ctrl_code_r;
            end else if (reg_addr_i == STAT_OFS) begin
                rdata_nxt[2:0] = state_r;
                rdata_nxt[3]   = (state_r != ST_IDLE) && (state_r != ST_DONE);
                rdata_nxt[4]   = def_sel_r;
                rdata_nxt[5]   = run_generic_r;
            end else if (reg_addr_i == DIV_OFS) begin
                rdata_nxt[DIV_W-1:0] = half_r;
            end else if (shadow_hit) begin
                rdata_nxt[DATA_W-1:0] = reg_shadow_data;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r        <= ST_IDLE;
            rst_cnt_r      <= '0;
            idx_r          <= '0;
            half_r         <= HALF_DEF_HI;
            def_sel_r      <= 1'b1;
            run_generic_r  <= GENERIC_RST;
            run_code_r     <= CODE_RST;
            ctrl_generic_r <= GENERIC_RST;
            ctrl_code_r    <= CODE_RST;
            tgt_wr_r       <= 1'b0;
            tgt_idx_r      <= '0;
            tgt_data_r     <= '0;
            tgt_rst_r      <= 1'b0;
            rdata_r        <= '0;
        end else begin
            state_r        <= state_nxt;
            rst_cnt_r      <= rst_cnt_nxt;
            idx_r          <= idx_nxt;
            half_r         <= half_nxt;
            def_sel_r      <= def_sel_nxt;
            run_generic_r  <= run_generic_nxt;
            run_code_r     <= run_code_nxt;
            ctrl_generic_r <= ctrl_generic_nxt;
            ctrl_code_r    <= ctrl_code_nxt;
            tgt_wr_r       <= tgt_wr_nxt;
            tgt_idx_r      <= tgt_idx_nxt;
            tgt_data_r     <= tgt_data_nxt;
            tgt_rst_r      <= tgt_rst_nxt;
            rdata_r        <= rdata_nxt;
        end
    end

    assign reg_rdata_o   = rdata_r;
    assign tgt_wr_o      = tgt_wr_r;
    assign tgt_wr_idx_o  = tgt_idx_r;
    assign tgt_wr_data_o = tgt_data_r;
    assign tgt_reset_o   = tgt_rst_r;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_def_rate;
        (state_r == ST_DEFRATE) ##1 (half_r == def_half);
    endsequence

    sequence s_load_start;
        (state_r == ST_LOAD) && tgt_wr_r;
    endsequence

    apply_resets_a: assert property (apply |=> tgt_rst_r && (state_r == ST_RESET))
        else $error("Apply did not reset the target.");

    reset_hold_a: assert property ($rose(tgt_rst_r) |-> tgt_rst_r [*8])
        else $error("Target reset pulse too short.");

    reset_end_a: assert property ((state_r == ST_RESET) && !apply && !mon_reset
                                  && (rst_cnt_r == RST_CNT_W'(TGT_RST_CYC - 1))
                                  |=> s_def_rate ##1 s_load_start)
        else $error("Default rate not set after target reset.");

    synth_default_a: assert property (tgt_wr_r && (tgt_idx_r == SYNTH_IDX) |-> (half_r == def_half))
        else $error("Synthesizer written above default rate.");

    skip_synth_a: assert property (tgt_wr_r && run_generic_r |-> (tgt_idx_r != SYNTH_IDX))
        else $error("Synthesizer written with generic type.");

    raise_rate_a: assert property ((state_r == ST_MAXRATE) && !apply && !mon_reset
                                   |=> (half_r == half_for_code(run_code_r)) && (state_r == ST_DONE))
        else $error("Link rate not raised after load.");

    user_reset_a: assert property (tgt_reset_seen_i && !tgt_in_monitor_i && !apply
                                   && ((state_r == ST_IDLE) || (state_r == ST_DONE))
                                   |=> $stable(half_r))
        else $error("Rate changed on user-code reset.");

    mon_reset_a: assert property (mon_reset && !apply |=> s_def_rate)
        else $error("Monitor reset did not rerun the load.");

    load_hold_a: assert property (tgt_wr_r && !tgt_wr_done_i && !apply && !mon_reset
                                  |=> tgt_wr_r && $stable(tgt_idx_r) && $stable(tgt_wr_data_o))
        else $error("Target write request dropped early.");

    load_next_a: assert property (tgt_wr_r && tgt_wr_done_i && (tgt_idx_r != LAST_IDX) && !apply && !mon_reset
                                  |=> !tgt_wr_r ##1 tgt_wr_r && (tgt_idx_r == $past(tgt_idx_r, 2) + 1'b1))
        else $error("Shadow entries not walked in order.");
endmodule

// File: drc_tgt_model.sv
// Behavioural target core seen through the debug port engine.
`timescale 1ns/1ps
module drc_tgt_model
    import drc_pkg::*;
#(
    parameter logic [DATA_W-1:0] SYNTH_DEF = 16'h0100
)
(
    // Clock and reset.
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    // Bench control: answer delay and an external target reset.
    input  wire logic [3:0]           lat_i,
    input  wire logic                 ext_reset_i,
    // Engine side.
    input  wire logic                 tgt_wr_i,
    input  wire logic [SHADOW_AW-1:0] tgt_wr_idx_i,
    input  wire logic [DATA_W-1:0]    tgt_wr_data_i,
    output logic                      tgt_wr_done_o,
    input  wire logic                 tgt_reset_i,
    output logic                      reset_seen_o
);
    logic [DATA_W-1:0] regs_r [SHADOW_N];
    logic              once_r;
    logic              busy_r;
    logic              acked_r;
    logic [3:0]        cnt_r;
    int                wr_total = 0;

    always @(posedge sys_clk_i) begin
        tgt_wr_done_o <= 1'b0;
        reset_seen_o  <= ext_reset_i;
        if (sys_rst_i || tgt_reset_i || ext_reset_i) begin
            // Every reset puts the synth control back to its default.
            for (int i = 0; i < SHADOW_N; i++) begin
                regs_r[i] <= (i == 0) ? SYNTH_DEF : '0;
            end
            once_r <= 1'b0;
        end
        if (sys_rst_i) begin
            busy_r  <= 1'b0;
            acked_r <= 1'b0;
        end else if (!busy_r) begin
            busy_r <= tgt_wr_i;
            cnt_r  <= lat_i;
        end else if (!acked_r) begin
            if (cnt_r == 4'h0) begin
                tgt_wr_done_o <= 1'b1;
                acked_r       <= 1'b1;
                wr_total      <= wr_total + 1;
                // The last register takes one write per reset; later ones are lost.
                if (tgt_wr_idx_i != LAST_IDX || !once_r) begin
                    regs_r[tgt_wr_idx_i] <= tgt_wr_data_i;
                end
                once_r <= once_r | (tgt_wr_idx_i == LAST_IDX);
            end else begin
                cnt_r <= cnt_r - 4'h1;
            end
        end else if (!tgt_wr_i) begin
            busy_r  <= 1'b0;
            acked_r <= 1'b0;
        end
    end
endmodule

// File: tb.sv
// Self-checking bench of the debug link rate loader.
`timescale 1ns/1ps
module tb;
    import drc_pkg::*;
    localparam logic [DATA_W-1:0] SYNTH_DEF = 16'h0100;
    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    logic [ADDR_W-1:0]    reg_addr_i = '0;
    logic [BUS_W-1:0]     reg_wdata_i = '0;
    logic                 reg_wr_i = 1'b0;
    logic                 reg_rd_i = 1'b0;
    logic [BUS_W-1:0]     reg_rdata_o;
    logic                 default_rate_switch_i = 1'b1;
    logic                 tgt_reset_seen_i;
    logic                 tgt_in_monitor_i = 1'b0;
    logic                 tgt_wr_o;
    logic [SHADOW_AW-1:0] tgt_wr_idx_o;
    logic [DATA_W-1:0]    tgt_wr_data_o;
    logic                 tgt_wr_done_i;
    logic                 tgt_reset_o;
    logic                 dbg_clk_o;
    logic [3:0]           lat = 4'h3;
    logic                 ext_reset = 1'b0;
    int                   fails = 0;
    int                   checks_done = 0;
    int                   cyc = 0;
    int                   base;
    int                   n;
    logic [BUS_W-1:0]     rv;
    int                   khz [8] = '{131, 8000, 12000, 16000, 20000, 25000, 33000, 40000};

    always #2.5 sys_clk_i = ~sys_clk_i;

    drc_loader_top drc_loader_top_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .default_rate_switch_i(default_rate_switch_i), .tgt_reset_seen_i(tgt_reset_seen_i),
        .tgt_in_monitor_i(tgt_in_monitor_i), .tgt_wr_o(tgt_wr_o), .tgt_wr_idx_o(tgt_wr_idx_o),
        .tgt_wr_data_o(tgt_wr_data_o), .tgt_wr_done_i(tgt_wr_done_i), .tgt_reset_o(tgt_reset_o),
        .dbg_clk_o(dbg_clk_o));
    drc_tgt_model #(.SYNTH_DEF(SYNTH_DEF)) drc_tgt_model_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .lat_i(lat), .ext_reset_i(ext_reset), .tgt_wr_i(tgt_wr_o), .tgt_wr_idx_i(tgt_wr_idx_o),
        .tgt_wr_data_i(tgt_wr_data_o), .tgt_wr_done_o(tgt_wr_done_i), .tgt_reset_i(tgt_reset_o),
        .reset_seen_o(tgt_reset_seen_i));

    function automatic logic [BUS_W-1:0] exp_half(input int k);
        return BUS_W'((SYS_CLK_KHZ * LINK_RATIO + 2 * k - 1) / (2 * k));
    endfunction
    function automatic logic [DATA_W-1:0] shv(input int i);
        return DATA_W'(16'ha501 + 16'h1111 * i);
    endfunction

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] exp, input string what);
        logic [BUS_W-1:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask

    // Polls the status word; the bound keeps a stuck sequencer from hanging the run.
    task automatic wait_st(input logic [2:0] st);
        logic [BUS_W-1:0] d;
        d = '0;
        for (int k = 0; k < 3000 && d[2:0] !== st; k++) begin
            rd(STAT_OFS, d);
        end
        chk(BUS_W'(d[2:0]), BUS_W'(st), "sequencer state");
    endtask

    task automatic run_apply(input logic [2:0] code, input logic gen, input int def_khz);
        int r;
        r = 0;
        base = drc_tgt_model_inst.wr_total;
        wr(CTRL_OFS, BUS_W'({code, 2'b00, gen, 1'b1}));
        for (int k = 0; k < 1000; k++) begin
            #1;
            if (tgt_reset_o === 1'b1) r++;
            else if (r > 0) break;
            @(posedge sys_clk_i);
        end
        chk(BUS_W'(r), BUS_W'(TGT_RST_CYC), "target reset length");
        chk(BUS_W'(drc_tgt_model_inst.wr_total - base), '0, "writes during reset");
        wait_st(3'h3);
        rdchk(DIV_OFS, exp_half(def_khz), "rate while loading");
        wait_st(3'h5);
        rdchk(DIV_OFS, exp_half(khz[code]), "rate after load");
        chk(BUS_W'(drc_tgt_model_inst.wr_total - base), gen ? 32'h7 : 32'h8, "write count");
        for (int i = 0; i < SHADOW_N; i++) begin
            chk(BUS_W'(drc_tgt_model_inst.regs_r[i]), (gen && i == 0) ? BUS_W'(SYNTH_DEF) : BUS_W'(shv(i)),
                "target register");
        end
    endtask

    task automatic target_reset(input logic mon);
        @(posedge sys_clk_i);
        tgt_in_monitor_i <= mon;
        ext_reset        <= 1'b1;
        @(posedge sys_clk_i);
        ext_reset <= 1'b0;
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 50000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rdchk(CTRL_OFS, 32'h10, "control after reset");
        rdchk(DIV_OFS, exp_half(8000), "divider after reset");
        rdchk(8'h44, '0, "unmapped read");
        for (int i = 0; i < SHADOW_N; i++) wr(ADDR_W'(32 + 4 * i), {16'hffff, shv(i)});
        for (int i = 0; i < SHADOW_N; i++) rdchk(ADDR_W'(32 + 4 * i), BUS_W'(shv(i)), "shadow");
        run_apply(3'h3, 1'b0, 8000);
        // Open switch with a slow target answer stretches every write handshake.
        default_rate_switch_i <= 1'b0;
        lat <= 4'h8;
        run_apply(3'h3, 1'b0, 131);
        default_rate_switch_i <= 1'b1;
        lat <= 4'h3;
        run_apply(3'h7, 1'b0, 8000);
        for (int j = 0; j < 2; j++) begin
            rv = BUS_W'(dbg_clk_o);
            n = 0;
            while (dbg_clk_o === rv[0] && n < 8000) begin
                @(posedge sys_clk_i);
                #1;
                n++;
            end
        end
        chk(BUS_W'(n), exp_half(40000), "serial clock half period");
        base = drc_tgt_model_inst.wr_total;
        target_reset(1'b1);
        wait_st(3'h3);
        rdchk(DIV_OFS, exp_half(8000), "monitor reset rate");
        wait_st(3'h5);
        rdchk(DIV_OFS, exp_half(40000), "monitor reset final rate");
        chk(BUS_W'(drc_tgt_model_inst.wr_total - base), 32'h8, "monitor reset writes");
        base = drc_tgt_model_inst.wr_total;
        target_reset(1'b0);
        repeat (40) @(posedge sys_clk_i);
        rdchk(DIV_OFS, exp_half(40000), "user reset rate");
        rd(STAT_OFS, rv);
        chk(BUS_W'(rv[5:0]), 32'h15, "user reset state");
        // Startup code would now reprogram the synthesizer; the loader must not do it for the target.
        chk(BUS_W'(drc_tgt_model_inst.regs_r[0]), BUS_W'(SYNTH_DEF), "synth after user reset");
        chk(BUS_W'(drc_tgt_model_inst.wr_total - base), '0, "user reset writes");
        run_apply(3'h2, 1'b1, 8000);
        print_verdict();
    end
endmodule
